// ===== hdl/sbcc_cond_detect.sv
// Start/stop condition detector on the synchronised bus lines
`timescale 1ns/1ps
module sbcc_cond_detect
   import sbcc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Bus lines from pins
   input  wire logic scl_pin,
   input  wire logic sda_pin,
   // Detected conditions
   output logic      start_pulse,
   output logic      stop_pulse
);

   // ----------------------------------------------------------------
   // Two-stage synchronisers
   // ----------------------------------------------------------------
   logic scl_meta_reg;
   logic scl_sync_reg;
   logic sda_meta_reg;
   logic sda_sync_reg;
   logic scl_prev_reg;
   logic sda_prev_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_meta_reg <= 1'b1;
         scl_sync_reg <= 1'b1;
         sda_meta_reg <= 1'b1;
         sda_sync_reg <= 1'b1;
      end
      else
      begin
         scl_meta_reg <= scl_pin;
         scl_sync_reg <= scl_meta_reg;
         sda_meta_reg <= sda_pin;
         sda_sync_reg <= sda_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // Edge finding on the synchronised copies only
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
         start_pulse  <= 1'b0;
         stop_pulse   <= 1'b0;
      end
      else
      begin
         scl_prev_reg <= scl_sync_reg;
         sda_prev_reg <= sda_sync_reg;
         // Data falls while clock stays high
         start_pulse  <= scl_prev_reg && scl_sync_reg && sda_prev_reg && !sda_sync_reg;
         // Data rises while clock stays high
         stop_pulse   <= scl_prev_reg && scl_sync_reg && !sda_prev_reg && sda_sync_reg;
      end
   end

endmodule : sbcc_cond_detect

// ===== hdl/sbcc_pkg.sv
// Shared constants for the serial bus condition control block
package sbcc_pkg;

   // ----------------------------------------------------------------
   // Bus widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_MODE     = 16'hFF60;
   localparam logic [ADDR_W-1:0] OFF_CTRL     = 16'hFF61;
   localparam logic [ADDR_W-1:0] OFF_SHIFT    = 16'hFF62;
   localparam logic [ADDR_W-1:0] OFF_SADDR    = 16'hFF63;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 16'hFF64;
   localparam logic [ADDR_W-1:0] OFF_IRQ_CLR  = 16'hFF65;
   localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 16'hFF66;

   // ----------------------------------------------------------------
   // Field positions of serial_bus_control
   // ----------------------------------------------------------------
   localparam int BIT_REL_TRIG = 0;
   localparam int BIT_CMD_TRIG = 1;
   localparam int BIT_REL_DET  = 2;
   localparam int BIT_CMD_DET  = 3;
   localparam int BIT_ACK_TRIG = 4;
   localparam int BIT_ACK_AUTO = 5;
   localparam int BIT_ACK_DET  = 6;
   localparam int BIT_BUSY_CTL = 7;

   // Mode register field
   localparam int BIT_IF_EN = 7;

   // ----------------------------------------------------------------
   // Interrupt status layout
   // ----------------------------------------------------------------
   localparam int IRQ_STOP      = 0;
   localparam int IRQ_START     = 1;
   localparam int IRQ_ADDR_MISS = 2;
   localparam int NUM_IRQ       = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0]  CTRL_RESET  = 8'h00;
   localparam logic [DATA_W-1:0]  ZERO_BYTE   = 8'h00;
   localparam logic [NUM_IRQ-1:0] IRQ_RESET   = 3'h0;
   localparam logic               LATCH_RESET = 1'b1;

endpackage : sbcc_pkg

// ===== hdl/sbcc_top.sv
// Condition control and detection of the serial bus interface
//
// What this block does
// R1 - The release trigger emits a bus release (proprietary mode) or a stop condition (I2C).
// R2 - Writing one to the release trigger sets the output latch, then the trigger self-clears and is held zero while disabled.
// R3 - The command trigger emits a command signal (proprietary mode) or a start condition (I2C).
// R4 - Writing one to the command trigger clears the output latch, then the trigger self-clears and is held zero while disabled.
// R5 - The release-detected flag clears on transfer start, while disabled, or on reset.
// R6 - The release-detected flag clears when a received address differs from the slave address.
// R7 - The release-detected flag sets on a detected bus release or stop condition.
// R8 - The command-detected flag clears on transfer start, while disabled, or on reset.
// R9 - The command-detected flag also clears when a bus release or stop condition is detected.
// R10 - The command-detected flag sets on a detected command signal or start condition.
// R11 - Bits 2, 3 and 6 of the control register are read-only and ignore writes.
// R12 - Bits 0, 1 and 4 of the control register always read back as zero.
// R13 - The interface enable bit stops or enables operation and gates the forced clears.
// R14 - Writing zero to either trigger leaves the output latch and the bus unchanged.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module sbcc_top
   import sbcc_pkg::*;
(
   // Clock and reset
   input  wire logic              CLK,
   input  wire logic              RST_B,
   // Register port
   input  wire logic [ADDR_W-1:0] REG_ADDR,
   input  wire logic [DATA_W-1:0] REG_WDATA,
   input  wire logic              REG_WR,
   input  wire logic              REG_RD,
   output logic      [DATA_W-1:0] REG_RDATA,
   // Received bytes from the shift logic
   input  wire logic [DATA_W-1:0] RX_BYTE,
   input  wire logic              RX_BYTE_VALID,
   input  wire logic              RX_IS_ADDRESS,
   // Transfer start towards the shift logic
   output logic      [DATA_W-1:0] TX_DATA,
   output logic                   XFER_START,
   // Serial clock and data pins
   input  wire logic              SCL_IN,
   input  wire logic              SDA_IN,
   output logic                   SDA_OUT,
   output logic                   SDA_OE_B,
   // Interrupt
   output logic                   IRQ
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_sync_reg;
   logic rst_n;

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   assign rst_n = rst_sync_reg;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic is_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] off);
      is_hit = (addr == off);
   endfunction : is_hit

   logic wr_mode;
   logic wr_ctrl;
   logic wr_shift;
   logic wr_saddr;
   logic wr_irq_clr;
   logic wr_irq_en;

   assign wr_mode    = REG_WR && is_hit(REG_ADDR, OFF_MODE);
   assign wr_ctrl    = REG_WR && is_hit(REG_ADDR, OFF_CTRL);
   assign wr_shift   = REG_WR && is_hit(REG_ADDR, OFF_SHIFT);
   assign wr_saddr   = REG_WR && is_hit(REG_ADDR, OFF_SADDR);
   assign wr_irq_clr = REG_WR && is_hit(REG_ADDR, OFF_IRQ_CLR);
   assign wr_irq_en  = REG_WR && is_hit(REG_ADDR, OFF_IRQ_EN);

   // ----------------------------------------------------------------
   // Interface enable
   // ----------------------------------------------------------------
   logic interface_enable_reg;

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         interface_enable_reg <= 1'b0;
      else if (wr_mode)
         interface_enable_reg <= REG_WDATA[BIT_IF_EN];                 // [R13]
   end

   // ----------------------------------------------------------------
   // Bus condition detection
   // ----------------------------------------------------------------
   logic start_pulse;
   logic stop_pulse;
   logic start_evt;
   logic stop_evt;

   sbcc_cond_detect u_detect (
      .clk         (CLK),
      .rst_n       (rst_n),
      .scl_pin     (SCL_IN),
      .sda_pin     (SDA_IN),
      .start_pulse (start_pulse),
      .stop_pulse  (stop_pulse)
   );

   // Conditions are ignored while the interface is stopped
   assign start_evt = interface_enable_reg && start_pulse;              // [R13]
   assign stop_evt  = interface_enable_reg && stop_pulse;               // [R13]

   // ----------------------------------------------------------------
   // Trigger bits
   // ----------------------------------------------------------------
   logic release_trigger_reg;
   logic command_trigger_reg;

   // Each trigger lives one cycle, long enough to move the latch
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         release_trigger_reg <= 1'b0;
         command_trigger_reg <= 1'b0;
      end
      else if (!interface_enable_reg)
      begin
         release_trigger_reg <= 1'b0;                                   // [R2]
         command_trigger_reg <= 1'b0;                                   // [R4]
      end
      else
      begin
         release_trigger_reg <= wr_ctrl && REG_WDATA[BIT_REL_TRIG];     // [R2] [R14]
         command_trigger_reg <= wr_ctrl && REG_WDATA[BIT_CMD_TRIG];     // [R4] [R14]
      end
   end

   // ----------------------------------------------------------------
   // Serial output latch
   // ----------------------------------------------------------------
   logic so_latch_reg;

   // Release wins when both triggers are written at once: a stop is safer
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         so_latch_reg <= LATCH_RESET;
      else if (release_trigger_reg)
         so_latch_reg <= 1'b1;                                          // [R1] [R2]
      else if (command_trigger_reg)
         so_latch_reg <= 1'b0;                                          // [R3] [R4]
      // A zero written to a trigger never reaches here             [R14]
   end

   // ----------------------------------------------------------------
   // Open-drain data pin
   // ----------------------------------------------------------------
   logic sda_oe_b_reg;

   // Line only pulled low while enabled and the latch holds zero
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         sda_oe_b_reg <= 1'b1;
      else
         sda_oe_b_reg <= !(interface_enable_reg && !so_latch_reg);     // [R1] [R3]
   end

   assign SDA_OUT  = 1'b0;
   assign SDA_OE_B = sda_oe_b_reg;

   // ----------------------------------------------------------------
   // Shift and slave address registers
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] shift_register_reg;
   logic [DATA_W-1:0] slave_address_reg;
   logic              xfer_start_reg;
   logic              addr_miss;

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         shift_register_reg <= ZERO_BYTE;
      else if (wr_shift)
         shift_register_reg <= REG_WDATA;
      else if (RX_BYTE_VALID)
         shift_register_reg <= RX_BYTE;
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         slave_address_reg <= ZERO_BYTE;
      else if (wr_saddr)
         slave_address_reg <= REG_WDATA;
   end

   // A write to the shift register is the transfer start instruction
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         xfer_start_reg <= 1'b0;
      else
         xfer_start_reg <= wr_shift && interface_enable_reg;
   end

   assign TX_DATA    = shift_register_reg;
   assign XFER_START = xfer_start_reg;

   assign addr_miss = interface_enable_reg && RX_BYTE_VALID && RX_IS_ADDRESS
                      && (RX_BYTE != slave_address_reg);                // [R6]

   // ----------------------------------------------------------------
   // Detection flags
   // ----------------------------------------------------------------
   logic release_detected_reg;
   logic command_detected_reg;

   // A detection in the same cycle as a clear is kept
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         release_detected_reg <= 1'b0;                                  // [R5]
      else if (!interface_enable_reg)
         release_detected_reg <= 1'b0;                                  // [R5] [R13]
      else if (stop_evt)
         release_detected_reg <= 1'b1;                                  // [R7]
      else if (wr_shift)
         release_detected_reg <= 1'b0;                                  // [R5]
      else if (addr_miss)
         release_detected_reg <= 1'b0;                                  // [R6]
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         command_detected_reg <= 1'b0;                                  // [R8]
      else if (!interface_enable_reg)
         command_detected_reg <= 1'b0;                                  // [R8] [R13]
      else if (start_evt)
         command_detected_reg <= 1'b1;                                  // [R10]
      else if (stop_evt)
         command_detected_reg <= 1'b0;                                  // [R9]
      else if (wr_shift)
         command_detected_reg <= 1'b0;                                  // [R8]
   end

   // ----------------------------------------------------------------
   // Plain storage bits of the control register
   // ----------------------------------------------------------------
   logic ack_auto_enable_reg;
   logic busy_output_reg;

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_auto_enable_reg <= CTRL_RESET[BIT_ACK_AUTO];
         busy_output_reg     <= CTRL_RESET[BIT_BUSY_CTL];
      end
      else if (wr_ctrl)
      begin
         ack_auto_enable_reg <= REG_WDATA[BIT_ACK_AUTO];
         busy_output_reg     <= REG_WDATA[BIT_BUSY_CTL];
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status, clear and enable
   // ----------------------------------------------------------------
   logic [NUM_IRQ-1:0] irq_event;
   logic [NUM_IRQ-1:0] irq_status_reg;
   logic [NUM_IRQ-1:0] irq_enable_reg;

   assign irq_event[IRQ_STOP]      = stop_evt;
   assign irq_event[IRQ_START]     = start_evt;
   assign irq_event[IRQ_ADDR_MISS] = addr_miss;

   // Set beats a clear written in the same cycle
   genvar gi;
   generate
      for (gi = 0; gi < NUM_IRQ; gi++)
      begin : g_irq
         always_ff @(posedge CLK or negedge rst_n)
         begin
            if (!rst_n)
               irq_status_reg[gi] <= IRQ_RESET[gi];
            else if (irq_event[gi])
               irq_status_reg[gi] <= 1'b1;
            else if (wr_irq_clr && REG_WDATA[gi])
               irq_status_reg[gi] <= 1'b0;
         end
      end
   endgenerate

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         irq_enable_reg <= IRQ_RESET;
      else if (wr_irq_en)
         irq_enable_reg <= REG_WDATA[NUM_IRQ-1:0];
   end

   assign IRQ = |(irq_status_reg & irq_enable_reg);

   // ----------------------------------------------------------------
   // Read back
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] ctrl_view;
   logic [DATA_W-1:0] rd_mux;
   logic [DATA_W-1:0] rdata_reg;

   // Triggers and the acknowledge flag are not stored here
   always_comb
   begin
      ctrl_view               = ZERO_BYTE;
      ctrl_view[BIT_REL_TRIG] = 1'b0;                                   // [R12]
      ctrl_view[BIT_CMD_TRIG] = 1'b0;                                   // [R12]
      ctrl_view[BIT_ACK_TRIG] = 1'b0;                                   // [R12]
      ctrl_view[BIT_REL_DET]  = release_detected_reg;                   // [R11]
      ctrl_view[BIT_CMD_DET]  = command_detected_reg;                   // [R11]
      ctrl_view[BIT_ACK_DET]  = 1'b0;                                   // [R11]
      ctrl_view[BIT_ACK_AUTO] = ack_auto_enable_reg;
      ctrl_view[BIT_BUSY_CTL] = busy_output_reg;
   end

   always_comb
   begin
      rd_mux = ZERO_BYTE;
      case (REG_ADDR)
         OFF_MODE:
         begin
            rd_mux[BIT_IF_EN] = interface_enable_reg;
         end
         OFF_CTRL:
         begin
            rd_mux = ctrl_view;
         end
         OFF_SHIFT:
         begin
            rd_mux = shift_register_reg;
         end
         OFF_SADDR:
         begin
            rd_mux = slave_address_reg;
         end
         OFF_IRQ_STAT:
         begin
            rd_mux[NUM_IRQ-1:0] = irq_status_reg;
         end
         OFF_IRQ_EN:
         begin
            rd_mux[NUM_IRQ-1:0] = irq_enable_reg;
         end
         default:
         begin
            rd_mux = ZERO_BYTE;
         end
      endcase
   end

   // Data valid only in the cycle after the strobe
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         rdata_reg <= ZERO_BYTE;
      else if (REG_RD)
         rdata_reg <= rd_mux;
      else
         rdata_reg <= ZERO_BYTE;
   end

   assign REG_RDATA = rdata_reg;

endmodule : sbcc_top

// ===== verification/sbcc_bus_partner.sv
// Far-side bus master making start, clock pulses and stop
`timescale 1ns/1ps
module sbcc_bus_partner
(
   // Lines driven from the far side
   output logic scl,
   output logic sda_rel
);
   // Half of the 160 ns link clock; data never moves near a clock edge
   localparam time HALF = 80ns;

   initial
   begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end

   task automatic start_cond();
      sda_rel = 1'b0;
      #(HALF);
   endtask : start_cond

   // Data held low while clocking, so no stray conditions
   task automatic clock_pulses(input int n);
      repeat (n)
      begin
         scl = 1'b0;
         #(HALF);
         scl = 1'b1;
         #(HALF);
      end
   endtask : clock_pulses

   task automatic stop_cond();
      sda_rel = 1'b0;
      #(HALF);
      sda_rel = 1'b1;
      #(HALF);
   endtask : stop_cond

   task automatic frame(input int n);
      start_cond();
      clock_pulses(n);
      stop_cond();
   endtask : frame
endmodule : sbcc_bus_partner

// ===== verification/sbcc_checker.sv
// Port-level assertions for the serial bus condition control block
`timescale 1ns/1ps
module sbcc_checker
   import sbcc_pkg::*;
(
   // Clock and reset
   input  wire logic              CLK,
   input  wire logic              RST_B,
   // Register port
   input  wire logic [ADDR_W-1:0] REG_ADDR,
   input  wire logic [DATA_W-1:0] REG_WDATA,
   input  wire logic              REG_WR,
   input  wire logic              REG_RD,
   input  wire logic [DATA_W-1:0] REG_RDATA,
   // Transfer start
   input  wire logic [DATA_W-1:0] TX_DATA,
   input  wire logic              XFER_START,
   // Pins and interrupt
   input  wire logic              SCL_IN,
   input  wire logic              SDA_IN,
   input  wire logic              SDA_OUT,
   input  wire logic              SDA_OE_B,
   input  wire logic              IRQ
);
   // ----------------------------------------------------------------
   // Shadow of enable, mask and time since a mode or trigger write
   // ----------------------------------------------------------------
   logic               en_reg;
   logic [NUM_IRQ-1:0] mask_reg;
   logic [2:0]         quiet_reg;
   logic               wr_ctrl;
   logic               wr_mode;
   assign wr_ctrl = REG_WR && (REG_ADDR == OFF_CTRL);
   assign wr_mode = REG_WR && (REG_ADDR == OFF_MODE);

   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B) en_reg <= 1'b0;
      else if (wr_mode) en_reg <= REG_WDATA[BIT_IF_EN];

   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B) mask_reg <= IRQ_RESET;
      else if (REG_WR && (REG_ADDR == OFF_IRQ_EN)) mask_reg <= REG_WDATA[NUM_IRQ-1:0];

   // Output lags a trigger by three cycles, so checks wait for quiet
   always_ff @(posedge CLK or negedge RST_B)
      if (!RST_B) quiet_reg <= 3'h7;
      else if (wr_mode || (wr_ctrl && REG_WDATA[1:0] != 2'h0)) quiet_reg <= 3'h0;
      else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   AST_SDA_OUT_LOW: assert property (SDA_OUT == 1'b0)
      else $error("SDA_OUT not low");
   AST_CMD_TRIG_PULLS: assert property (
      wr_ctrl && en_reg && REG_WDATA[1:0] == 2'h2 |-> ##3 !SDA_OE_B)
      else $error("command trigger did not pull data low");
   AST_REL_TRIG_RELEASES: assert property (
      wr_ctrl && en_reg && REG_WDATA[BIT_REL_TRIG] |-> ##3 SDA_OE_B)
      else $error("release trigger did not release data");
   AST_ZERO_TRIG_HOLDS: assert property (
      wr_ctrl && REG_WDATA[1:0] == 2'h0 && quiet_reg >= 3'h4 |=> $stable(SDA_OE_B) [*3])
      else $error("zero trigger write moved the data line");
   AST_DISABLED_RELEASED: assert property (!en_reg && quiet_reg >= 3'h2 |-> SDA_OE_B)
      else $error("data line driven while disabled");
   AST_TRIG_READS_ZERO: assert property (REG_RD && REG_ADDR == OFF_CTRL
      |=> !REG_RDATA[BIT_REL_TRIG] && !REG_RDATA[BIT_CMD_TRIG] && !REG_RDATA[BIT_ACK_TRIG])
      else $error("trigger bit read back as one");
   AST_DISABLED_NO_FLAGS: assert property (REG_RD && REG_ADDR == OFF_CTRL && !en_reg
      && quiet_reg >= 3'h2 |=> !REG_RDATA[BIT_REL_DET] && !REG_RDATA[BIT_CMD_DET])
      else $error("detect flag set while disabled");
   AST_XFER_PULSE: assert property (REG_WR && REG_ADDR == OFF_SHIFT && en_reg
      |=> XFER_START && TX_DATA == $past(REG_WDATA) ##1 !XFER_START)
      else $error("transfer start pulse wrong");
   AST_START_RAISES_IRQ: assert property ($fell(SDA_IN) && SCL_IN && en_reg
      && mask_reg[IRQ_START] |-> ##[3:8] IRQ)
      else $error("start condition not flagged");
   AST_STOP_RAISES_IRQ: assert property ($rose(SDA_IN) && SCL_IN && en_reg
      && mask_reg[IRQ_STOP] |-> ##[3:8] IRQ)
      else $error("stop condition not flagged");
endmodule : sbcc_checker

bind sbcc_top sbcc_checker i_checker (
   .CLK        (CLK),
   .RST_B      (RST_B),
   .REG_ADDR   (REG_ADDR),
   .REG_WDATA  (REG_WDATA),
   .REG_WR     (REG_WR),
   .REG_RD     (REG_RD),
   .REG_RDATA  (REG_RDATA),
   .TX_DATA    (TX_DATA),
   .XFER_START (XFER_START),
   .SCL_IN     (SCL_IN),
   .SDA_IN     (SDA_IN),
   .SDA_OUT    (SDA_OUT),
   .SDA_OE_B   (SDA_OE_B),
   .IRQ        (IRQ)
);

// ===== verification/sbcc_top_tb.sv
// Self-checking bench for the serial bus condition control block
`timescale 1ns/1ps
module sbcc_top_tb
   import sbcc_pkg::*;
;
   logic              clk, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, rxv = 1'b0, rxa = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0, rxb = '0, rdata, txd;
   logic              xfer, sda_out, oe_b, irq, scl, sda_rel, rd_pend = 1'b0;
   wire               sda_line = sda_rel & oe_b;
   logic [DATA_W-1:0] exp_q[$];
   logic [31:0]       rng = 32'h5;
   int                error_cnt = 0, checked = 0;

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   sbcc_top i_dut (
      .CLK (clk), .RST_B (rst_b), .REG_ADDR (addr), .REG_WDATA (wdata),
      .REG_WR (wr), .REG_RD (rd), .REG_RDATA (rdata), .RX_BYTE (rxb),
      .RX_BYTE_VALID (rxv), .RX_IS_ADDRESS (rxa), .TX_DATA (txd), .XFER_START (xfer),
      .SCL_IN (scl), .SDA_IN (sda_line), .SDA_OUT (sda_out), .SDA_OE_B (oe_b), .IRQ (irq));

   sbcc_bus_partner i_partner (.scl (scl), .sda_rel (sda_rel));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   task automatic check(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] act);
      checked++;
      if (act !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, act);
      end
   endtask : check

   task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask : reg_rd

   task automatic rx_byte(input logic [DATA_W-1:0] b);
      @(posedge clk);
      rxb <= b;
      rxv <= 1'b1;
      rxa <= 1'b1;
      @(posedge clk);
      rxv <= 1'b0;
   endtask : rx_byte

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle

   task automatic finish_test();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   // Read data stand only in the cycle after the strobe
   always @(posedge clk)
   begin
      if (rd_pend === 1'b1)
         check("read data", exp_q.pop_front(), rdata);
      rd_pend <= rd;
   end

   // Whole sequence needs well under 10 us
   initial
   begin
      #100us;
      error_cnt++;
      $display("Error watchdog expected end seen timeout");
      finish_test();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      idle(3);
      reg_rd(OFF_CTRL, CTRL_RESET);
      reg_rd(OFF_MODE, ZERO_BYTE);
      reg_rd(16'hFF70, ZERO_BYTE);
      #1 check("oe_b reset", 8'h01, {7'h00, oe_b});
      // Disabled: triggers and bus traffic are ignored
      reg_wr(OFF_IRQ_EN, 8'h07);
      reg_wr(OFF_CTRL, 8'h02);
      #7 i_partner.frame(4);
      idle(10);
      check("oe_b disabled", 8'h01, {7'h00, oe_b});
      reg_rd(OFF_CTRL, ZERO_BYTE);
      reg_rd(OFF_IRQ_STAT, ZERO_BYTE);
      // Own command pulls data low with clock high: a start
      reg_wr(OFF_MODE, 8'h80);
      reg_wr(OFF_CTRL, 8'h02);
      idle(10);
      check("oe_b command", 8'h00, {7'h00, oe_b});
      check("irq start", 8'h01, {7'h00, irq});
      reg_rd(OFF_CTRL, 8'h08);
      reg_wr(OFF_CTRL, 8'h00);
      idle(10);
      check("oe_b zero write", 8'h00, {7'h00, oe_b});
      reg_wr(OFF_CTRL, 8'h03);
      idle(10);
      check("oe_b release", 8'h01, {7'h00, oe_b});
      reg_rd(OFF_CTRL, 8'h04);
      reg_rd(OFF_IRQ_STAT, 8'h03);
      reg_wr(OFF_CTRL, 8'hFC);
      reg_rd(OFF_CTRL, 8'hA4);
      reg_wr(OFF_CTRL, 8'h00);
      // Address compare
      reg_wr(OFF_SADDR, 8'h5A);
      reg_rd(OFF_SADDR, 8'h5A);
      rx_byte(8'h5A);
      reg_rd(OFF_SHIFT, 8'h5A);
      reg_rd(OFF_CTRL, 8'h04);
      rng = xorshift(rng);
      rx_byte(8'h5A ^ (rng[7:0] | 8'h01));
      reg_rd(OFF_CTRL, 8'h00);
      reg_rd(OFF_IRQ_STAT, 8'h07);
      // Interrupt masked, then cleared
      reg_wr(OFF_IRQ_EN, 8'h00);
      idle(1);
      check("irq masked", 8'h00, {7'h00, irq});
      reg_wr(OFF_IRQ_CLR, 8'h07);
      reg_rd(OFF_IRQ_STAT, 8'h00);
      reg_wr(OFF_IRQ_EN, 8'h07);
      reg_rd(OFF_IRQ_EN, 8'h07);
      idle(1);
      check("irq cleared", 8'h00, {7'h00, irq});
      // Far-side start, transfer start, then far-side stop
      #7 i_partner.start_cond();
      idle(10);
      reg_rd(OFF_CTRL, 8'h08);
      rng = xorshift(rng);
      reg_wr(OFF_SHIFT, rng[7:0]);
      idle(1);
      check("tx data", rng[7:0], txd);
      reg_rd(OFF_CTRL, 8'h00);
      #7 i_partner.clock_pulses(4);
      i_partner.stop_cond();
      idle(10);
      reg_rd(OFF_CTRL, 8'h04);
      reg_rd(OFF_IRQ_STAT, 8'h03);
      reg_wr(OFF_MODE, 8'h00);
      reg_rd(OFF_CTRL, ZERO_BYTE);
      idle(3);
      finish_test();
   end
endmodule : sbcc_top_tb
